// >>> design/mckt_pkg.sv
// Package with register map, field layout, reset values and carrier types for the keyscan block.
package mckt_pkg;

    // Register offsets on the serial control port.
    localparam logic [7:0] OFS_MIC_BIAS_AND_GAIN = 8'h09;
    localparam logic [7:0] OFS_MAKER_IDENTIFICATION = 8'h0b;
    localparam logic [7:0] OFS_SCAN_TICK_DIVISOR_UPPER = 8'h12;
    localparam logic [7:0] OFS_SCAN_TICK_DIVISOR_LOWER = 8'h13;
    localparam logic [7:0] OFS_CONVERTER_CLOCK_DIVISOR = 8'h14;
    localparam logic [7:0] OFS_PRESS_DEBOUNCE_TIME = 8'h15;

    // Field positions inside the microphone register.
    localparam int GAIN_BIT = 6;
    localparam int RES_SEL_MSB = 5;
    localparam int RES_SEL_LSB = 3;
    localparam int BIAS_VOLT_BIT = 2;

    // Maker identification sits in the upper nibble; the value is arbitrary.
    localparam int ID_LSB = 4;
    localparam logic [3:0] MAKER_ID_VALUE = 4'h5;

    // Writable bits of the microphone register; all others read as zero.
    localparam logic [7:0] MIC_WRITE_MASK = 8'h7c;

    // Reset values of the writable registers.
    localparam logic [7:0] MIC_RESET = 8'h00;
    localparam logic [15:0] TICK_DIV_RESET = 16'h0000;
    localparam logic [7:0] CONV_DIV_RESET = 8'h00;
    localparam logic [7:0] DEB_RESET = 8'h00;

    // Resistor selection codes of the three-bit field.
    localparam logic [2:0] RES_2K2 = 3'h0;
    localparam logic [2:0] RES_2K6 = 3'h1;
    localparam logic [2:0] RES_3K0 = 3'h2;
    localparam logic [2:0] RES_BYPASS = 3'h3;

    // One register access from the serial front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mckt_reg_req_t;

    // Decoded analog settings of the microphone path.
    typedef struct packed {
        logic gain_24db;
        logic bias_2v6;
        logic res_2k2;
        logic res_2k6;
        logic res_3k0;
        logic res_bypass;
        logic bias_sleep;
    } mckt_mic_ctl_t;

endpackage : mckt_pkg

// >>> design/mckt_keyscan_regs.sv
// Microphone configuration registers with keyscan tick, converter clock and press debounce.

module mckt_keyscan_regs (
    input wire logic mclk,
    input wire logic rst_b,
    input wire mckt_pkg::mckt_reg_req_t reg_req,
    output logic [7:0] rd_data,
    input wire logic reference_input_clock,
    input wire logic key_detect,
    output mckt_pkg::mckt_mic_ctl_t mic_ctl,
    output logic scan_tick,
    output logic converter_clock,
    output logic key_valid
);

    // Reset release through two flip-flops; the copy rst_sync_b drives everything else.
    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // Pin synchronisers; the first stage is read only by the second.
    logic ref_meta;
    logic ref_sync;
    logic ref_prev;
    logic key_meta;
    logic key_sync;
    logic key_prev;

    // Both pins come from outside the mclk domain, so they pass two flops first.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
            key_meta <= 1'b0;
            key_sync <= 1'b0;
            key_prev <= 1'b0;
        end else begin
            ref_meta <= reference_input_clock;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
            key_meta <= key_detect;
            key_sync <= key_meta;
            key_prev <= key_sync;
        end
    end

    // Rising edge of the reference clock; mclk must run well above twice its rate.
    wire ref_rise = ref_sync & ~ref_prev;
    // Rising edge of the keypress detector.
    wire key_rise = key_sync & ~key_prev;

    // Writable register storage.
    logic [7:0] mic_reg;
    logic [15:0] tick_div;
    logic [7:0] conv_div;
    logic [7:0] deb_code;

    // Write decode, one wire per writable register.
    wire wr_mic = reg_req.wr && (reg_req.addr == mckt_pkg::OFS_MIC_BIAS_AND_GAIN);
    wire wr_upper = reg_req.wr && (reg_req.addr == mckt_pkg::OFS_SCAN_TICK_DIVISOR_UPPER);
    wire wr_lower = reg_req.wr && (reg_req.addr == mckt_pkg::OFS_SCAN_TICK_DIVISOR_LOWER);
    wire wr_conv = reg_req.wr && (reg_req.addr == mckt_pkg::OFS_CONVERTER_CLOCK_DIVISOR);
    wire wr_deb = reg_req.wr && (reg_req.addr == mckt_pkg::OFS_PRESS_DEBOUNCE_TIME);

    // Register writes; unused microphone bits are masked off so they never store.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mic_reg <= mckt_pkg::MIC_RESET;
            tick_div <= mckt_pkg::TICK_DIV_RESET;
            conv_div <= mckt_pkg::CONV_DIV_RESET;
            deb_code <= mckt_pkg::DEB_RESET;
        end else begin
            if (wr_mic) begin
                mic_reg <= reg_req.wdata & mckt_pkg::MIC_WRITE_MASK;
            end
            if (wr_upper) begin
                tick_div[15:8] <= reg_req.wdata;
            end
            if (wr_lower) begin
                tick_div[7:0] <= reg_req.wdata;
            end
            if (wr_conv) begin
                conv_div <= reg_req.wdata;
            end
            if (wr_deb) begin
                deb_code <= reg_req.wdata;
            end
        end
    end

    // Identification word: fixed upper nibble, zero below.
    wire [7:0] id_word = {mckt_pkg::MAKER_ID_VALUE, 4'h0};

    // Read selection; an unmapped offset answers zero.
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_req.addr)
            mckt_pkg::OFS_MIC_BIAS_AND_GAIN: rd_mux = mic_reg;
            mckt_pkg::OFS_MAKER_IDENTIFICATION: rd_mux = id_word;
            mckt_pkg::OFS_SCAN_TICK_DIVISOR_UPPER: rd_mux = tick_div[15:8];
            mckt_pkg::OFS_SCAN_TICK_DIVISOR_LOWER: rd_mux = tick_div[7:0];
            mckt_pkg::OFS_CONVERTER_CLOCK_DIVISOR: rd_mux = conv_div;
            mckt_pkg::OFS_PRESS_DEBOUNCE_TIME: rd_mux = deb_code;
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data is captured on the read strobe and held until the next read.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rd_data <= 8'h00;
        end else if (reg_req.rd) begin
            rd_data <= rd_mux;
        end
    end

    // Microphone settings decode from the stored register.
    wire [2:0] res_code = mic_reg[mckt_pkg::RES_SEL_MSB:mckt_pkg::RES_SEL_LSB];
    wire res_sleep = res_code[2];
    mckt_pkg::mckt_mic_ctl_t next_mic_ctl;

    always_comb begin
        next_mic_ctl.gain_24db = mic_reg[mckt_pkg::GAIN_BIT];
        next_mic_ctl.bias_2v6 = mic_reg[mckt_pkg::BIAS_VOLT_BIT];
        // Any code with the top bit set wins over the low bits and parks the bias.
        next_mic_ctl.bias_sleep = res_sleep;
        next_mic_ctl.res_2k2 = !res_sleep && (res_code == mckt_pkg::RES_2K2);
        next_mic_ctl.res_2k6 = !res_sleep && (res_code == mckt_pkg::RES_2K6);
        next_mic_ctl.res_3k0 = !res_sleep && (res_code == mckt_pkg::RES_3K0);
        next_mic_ctl.res_bypass = !res_sleep && (res_code == mckt_pkg::RES_BYPASS);
    end

    // Outputs are registered so the analog side never sees decode glitches.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mic_ctl <= '0;
        end else begin
            mic_ctl <= next_mic_ctl;
        end
    end

    // Half-period compare: toggle when count reaches divisor minus one; zero acts as one.
    function automatic logic half_done(input logic [15:0] cnt, input logic [15:0] div);
        logic [15:0] lim;
        lim = (div == 16'h0000) ? 16'h0000 : 16'(div - 16'h0001);
        return cnt >= lim;
    endfunction

    // Keyscan tick divider: N reference edges per half period gives f_in/(2N).
    logic [15:0] tick_cnt;
    logic tick_clk;
    wire tick_half = ref_rise && half_done(tick_cnt, tick_div);
    wire tick_event = tick_half && !tick_clk;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tick_cnt <= 16'h0000;
            tick_clk <= 1'b0;
            scan_tick <= 1'b0;
        end else begin
            if (tick_half) begin
                tick_cnt <= 16'h0000;
                tick_clk <= !tick_clk;
            end else if (ref_rise) begin
                tick_cnt <= tick_cnt + 16'h0001;
            end
            scan_tick <= tick_event;
        end
    end

    // Converter clock divider; eight-bit divisor with the same half-period scheme.
    logic [7:0] conv_cnt;
    wire conv_half = ref_rise && half_done({8'h00, conv_cnt}, {8'h00, conv_div});

    // The toggled level is the converter's conversion clock pin.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            conv_cnt <= 8'h00;
            converter_clock <= 1'b0;
        end else if (conv_half) begin
            conv_cnt <= 8'h00;
            converter_clock <= !converter_clock;
        end else if (ref_rise) begin
            conv_cnt <= conv_cnt + 8'h01;
        end
    end

    // Debounce: idle until a press, then count code plus one ticks.
    typedef enum logic [0:0] {MCKT_IDLE, MCKT_BOUNCE} mckt_deb_state_t;
    mckt_deb_state_t deb_state;
    logic [8:0] deb_left;
    // A press ends without validation if the line releases during the wait.
    wire deb_done = (deb_state == MCKT_BOUNCE) && tick_event && (deb_left == 9'h001);

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            deb_state <= MCKT_IDLE;
            deb_left <= 9'h000;
            key_valid <= 1'b0;
        end else begin
            key_valid <= 1'b0;
            if (key_rise) begin
                // A new press always restarts the interval.
                deb_state <= MCKT_BOUNCE;
                deb_left <= {1'b0, deb_code} + 9'h001;
            end else begin
                case (deb_state)
                    MCKT_IDLE: begin
                        deb_left <= 9'h000;
                    end
                    MCKT_BOUNCE: begin
                        if (!key_sync) begin
                            deb_state <= MCKT_IDLE;
                        end else if (deb_done) begin
                            deb_state <= MCKT_IDLE;
                            key_valid <= 1'b1;
                        end else if (tick_event) begin
                            deb_left <= deb_left - 9'h001;
                        end
                    end
                    default: begin
                        deb_state <= MCKT_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // mckt_keyscan_regs

// >>> tb/mckt_keyscan_chk.sv
// Checker for the keyscan register block ports.
module mckt_keyscan_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire mckt_pkg::mckt_reg_req_t reg_req,
    input wire logic [7:0] rd_data,
    input wire mckt_pkg::mckt_mic_ctl_t mic_ctl,
    input wire logic scan_tick,
    input wire logic key_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // A write to the microphone register shows two cycles later.
    property p_gain;
        reg_req.wr && reg_req.addr == 8'h09 |=> ##1 mic_ctl.gain_24db == $past(reg_req.wdata[6], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain select wrong");
    property p_bias;
        reg_req.wr && reg_req.addr == 8'h09 |=> ##1 mic_ctl.bias_2v6 == $past(reg_req.wdata[2], 2);
    endproperty
    a_bias: assert property (p_bias) else $error("bias voltage wrong");
    property p_sleep_code;
        reg_req.wr && reg_req.addr == 8'h09 |=> ##1 mic_ctl.bias_sleep == $past(reg_req.wdata[5], 2);
    endproperty
    a_sleep_code: assert property (p_sleep_code) else $error("sleep decode wrong");
    // Sleep must leave every resistor open.
    property p_sleep_open;
        mic_ctl.bias_sleep |-> !(mic_ctl.res_2k2 || mic_ctl.res_2k6 || mic_ctl.res_3k0 || mic_ctl.res_bypass);
    endproperty
    a_sleep_open: assert property (p_sleep_open) else $error("resistor on in sleep");
    property p_id;
        reg_req.rd && reg_req.addr == 8'h0b |=> rd_data == {mckt_pkg::MAKER_ID_VALUE, 4'h0};
    endproperty
    a_id: assert property (p_id) else $error("maker id wrong");
    property p_unused;
        reg_req.rd && reg_req.addr == 8'h09 |=> rd_data[7] == 1'b0 && rd_data[1:0] == 2'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    property p_tick;
        scan_tick |=> !scan_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too long");
    property p_valid;
        $rose(key_valid) |=> !key_valid;
    endproperty
    a_valid: assert property (p_valid) else $error("press pulse too long");
    // A press can only be accepted on the cycle that a keyscan tick is shown.
    property p_valid_tick;
        key_valid |-> scan_tick;
    endproperty
    a_valid_tick: assert property (p_valid_tick) else $error("press accepted off tick");
endmodule // mckt_keyscan_chk

// >>> tb/mckt_host_model.sv
// Host model: register requests and a free-running reference clock.
module mckt_host_model (
    input wire logic mclk,
    input wire logic [7:0] rd_data,
    output mckt_pkg::mckt_reg_req_t reg_req,
    output logic reference_input_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    // The reference runs at a fifth of mclk, safely under the quarter-rate limit.
    initial begin
        reg_req = '0;
        reference_input_clock = 1'b0;
        #7;
        forever #100 reference_input_clock = ~reference_input_clock;
    end
    // One-cycle request pulse; read data is taken half a cycle after the sampling edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] q);
        @(negedge mclk);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: wd};
        @(negedge mclk);
        reg_req = '0;
        q = rd_data;
    endtask
endmodule // mckt_host_model

// >>> tb/testbench.sv
// Self-checking bench for the keyscan register block.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk;
    logic rst_b;
    logic key_detect;
    mckt_pkg::mckt_reg_req_t reg_req;
    mckt_pkg::mckt_mic_ctl_t mic_ctl;
    logic [7:0] rd_data;
    logic [7:0] d;
    logic ref_clk;
    logic scan_tick;
    logic converter_clock;
    logic key_valid;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    mckt_keyscan_regs uut (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
        .reference_input_clock(ref_clk), .key_detect(key_detect), .mic_ctl(mic_ctl),
        .scan_tick(scan_tick), .converter_clock(converter_clock), .key_valid(key_valid));
    mckt_host_model host (.mclk(mclk), .rd_data(rd_data), .reg_req(reg_req),
        .reference_input_clock(ref_clk));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Cut a hang short; the tests need well under half this.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // Cycles between two events; the first interval may straddle a divisor change.
    task automatic gap(input bit conv, output int n);
        logic p;
        repeat (2) begin
            p = converter_clock;
            n = 0;
            do begin
                @(negedge mclk);
                n++;
            end while (conv ? converter_clock === p : scan_tick !== 1'b1);
        end
    endtask
    // Every resistor code, with unused bits set on write.
    task automatic t_mic();
        logic [7:0] w;
        mckt_pkg::mckt_mic_ctl_t e;
        for (int i = 0; i < 8; i++) begin
            w = {1'b1, i[0], i[2:0], i[1], 2'h3};
            e = '{gain_24db: i[0], bias_2v6: i[1], res_2k2: i[2:0] == 3'h0,
                res_2k6: i[2:0] == 3'h1, res_3k0: i[2:0] == 3'h2,
                res_bypass: i[2:0] == 3'h3, bias_sleep: i[2]};
            host.xfer(1'b1, 8'h09, w, d);
            host.xfer(1'b0, 8'h09, 8'h00, d);
            chk("mic_ctl", 16'(e), 16'(mic_ctl));
            chk("mic read", {8'h00, w & 8'h7c}, {8'h00, d});
        end
    endtask
    task automatic t_id();
        host.xfer(1'b1, 8'h0b, 8'h0f, d);
        host.xfer(1'b0, 8'h0b, 8'h00, d);
        chk("maker id", {8'h00, mckt_pkg::MAKER_ID_VALUE, 4'h0}, {8'h00, d});
        host.xfer(1'b0, 8'h20, 8'h00, d);
        chk("unmapped", 16'h0000, {8'h00, d});
    endtask
    // Divisor 0x0102 gives a tick every 516 reference rises; 3 gives a 15-cycle half period.
    task automatic t_div();
        int n;
        host.xfer(1'b1, 8'h12, 8'h01, d);
        host.xfer(1'b1, 8'h13, 8'h02, d);
        host.xfer(1'b1, 8'h14, 8'h03, d);
        host.xfer(1'b0, 8'h12, 8'h00, d);
        chk("tick upper", 16'h0001, {8'h00, d});
        host.xfer(1'b0, 8'h13, 8'h00, d);
        chk("tick lower", 16'h0002, {8'h00, d});
        host.xfer(1'b0, 8'h14, 8'h00, d);
        chk("conv divisor", 16'h0003, {8'h00, d});
        gap(1'b1, n);
        chk("conv half", 16'h000f, 16'(n));
        gap(1'b0, n);
        chk("tick period", 16'h0a14, 16'(n));
    endtask
    // Press just after a tick, count ticks until the press is accepted.
    task automatic t_deb(input logic [7:0] code, input int hold);
        int n;
        int v;
        n = 0;
        v = 0;
        host.xfer(1'b1, 8'h15, code, d);
        host.xfer(1'b0, 8'h15, 8'h00, d);
        chk("debounce code", {8'h00, code}, {8'h00, d});
        do @(negedge mclk); while (scan_tick !== 1'b1);
        key_detect = 1'b1;
        for (int k = 0; k < 300 && v == 0; k++) begin
            @(negedge mclk);
            n += (scan_tick === 1'b1);
            v += (key_valid === 1'b1);
            if (k == hold) key_detect = 1'b0;
        end
        key_detect = 1'b0;
        repeat (30) @(negedge mclk);
        if (hold > 200) chk("debounce ticks", 16'(code) + 16'h0001, 16'(n));
        else chk("aborted press", 16'h0000, 16'(v));
    endtask
    initial begin
        rst_b = 1'b0;
        key_detect = 1'b0;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        t_mic();
        t_id();
        t_div();
        host.xfer(1'b1, 8'h12, 8'h00, d);
        host.xfer(1'b1, 8'h13, 8'h01, d);
        t_deb(8'h00, 400);
        t_deb(8'h02, 400);
        t_deb(8'h02, 12);
        stop_test();
    end
endmodule // testbench
bind mckt_keyscan_regs mckt_keyscan_chk chk (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
    .rd_data(rd_data), .mic_ctl(mic_ctl), .scan_tick(scan_tick), .key_valid(key_valid));
